// file: verilog/power_cfg_pkg.sv
// Package with register map, field positions, reset values and bus carriers
package power_cfg_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;

	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_CLOCK_PHASE = 12'h108;
	localparam logic [ADDR_W-1:0] IDX_OUTPUT_IF   = 12'h109;
	localparam logic [ADDR_W-1:0] IDX_BUCK_AUTO   = 12'h10A;
	localparam logic [ADDR_W-1:0] IDX_LIN_BYPASS  = 12'h10B;
	localparam logic [ADDR_W-1:0] IDX_LIN_AUTO    = 12'h10C;
	localparam logic [ADDR_W-1:0] IDX_MERGE_MODE  = 12'h10D;
	localparam int               BYTE_SHIFT      = 2;

	localparam logic [REG_W-1:0] RST_CLOCK_PHASE = 8'h00;
	localparam logic [REG_W-1:0] RST_OUTPUT_IF   = 8'h40;
	localparam logic [REG_W-1:0] RST_BUCK_AUTO   = 8'h00;
	localparam logic [REG_W-1:0] RST_LIN_BYPASS  = 8'h00;
	localparam logic [REG_W-1:0] RST_LIN_AUTO    = 8'h00;
	localparam logic [REG_W-1:0] RST_MERGE_MODE  = 8'h00;

	// clock_phase_discharge_cfg
	localparam int B_PERI_CLK_INV  = 7;
	localparam int B_IO_CLK_INV    = 6;
	localparam int B_MEM_CLK_INV   = 5;
	localparam int B_PRO_CLK_INV   = 4;
	localparam int B_CORE1_CLK_INV = 3;
	localparam int B_DISCHARGE     = 2;
	// output_interface_cfg
	localparam int B_FB3_POL       = 7;
	localparam int B_FB2_POL       = 6;
	localparam int B_FORCE_RESET   = 5;
	localparam int B_HS_CONT       = 4;
	localparam int B_HS_FMP        = 3;
	localparam int B_SYSEN_KEEP    = 2;
	localparam int B_IRQ_DEFER     = 1;
	localparam int B_SUPPLY_SEL    = 0;
	// linear_bypass_autostart
	localparam int B_L11_BYP       = 7;
	localparam int B_L8_BYP        = 6;
	localparam int B_L7_BYP        = 5;
	localparam int B_L3_BYP        = 3;
	localparam int B_L11_AUTO      = 2;
	localparam int B_L9_AUTO       = 0;
	// linear_autostart_select
	localparam int B_L8_AUTO       = 7;
	localparam int B_L7_AUTO       = 6;
	localparam int B_L3_AUTO       = 2;
	// memory_io_buck_join_mode_cfg
	localparam int B_MEM_IO_JOIN   = 7;
	localparam int B_CORE1_FULL    = 6;
	localparam int B_CORE2_FULL    = 5;
	localparam int B_PRO_FULL      = 4;
	localparam int B_DUAL_PHASE    = 3;
	localparam int B_SENSE_ROUTE   = 2;
	localparam int B_L8_FUNC       = 1;

	// Linear regulator vector order: {11, 9, 8, 7, 3}
	localparam int N_BUCK_RAILS = 8;
	localparam int N_LIN_RAILS  = 5;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} axil_req_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic [1:0]        bresp;
		logic              bvalid;
		logic              arready;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic              rvalid;
	} axil_rsp_t;

endpackage : power_cfg_pkg

// file: verilog/feedback_pin_driver.sv
// Feedback output pin driver with polarity and open-drain selection
`timescale 1ns/10ps
module feedback_pin_driver (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic source,
	input  wire logic active_high,
	input  wire logic open_drain,
	input  wire logic enable,
	output logic      pin_o,
	output logic      pin_oe
);

	logic level;

	// Active low inverts the internal signal
	assign level = active_high ? source : ~source;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_o  <= 1'b0;
			pin_oe <= 1'b0;
		end else if (!enable) begin
			pin_o  <= 1'b0;
			pin_oe <= 1'b0;
		end else if (open_drain) begin
			// Open drain only pulls low; high comes from the external pull-up
			pin_o  <= 1'b0;
			pin_oe <= ~level;
		end else begin
			pin_o  <= level;
			pin_oe <= 1'b1;
		end
	end

endmodule : feedback_pin_driver

// file: verilog/pmic_power_config_bank.sv
// Customer power configuration register bank with AXI4-Lite access
`timescale 1ns/10ps

module pmic_power_config_bank
	import power_cfg_pkg::*;
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire axil_req_t              s_req,
	output axil_rsp_t                   s_rsp,
	// Sequencer and converter side
	input  wire logic [N_BUCK_RAILS-1:0] buck_conf_enable,
	input  wire logic [N_LIN_RAILS-1:0]  linear_conf_enable,
	input  wire logic                   reset_request,
	input  wire logic                   irq_event_pending,
	input  wire logic                   power_mode_active,
	input  wire logic                   otp_read_done,
	input  wire logic                   otp_read_second,
	input  wire logic                   otp_system_en,
	input  wire logic                   fb_three_source,
	input  wire logic                   fb_two_source,
	input  wire logic                   fb_two_is_power_good,
	input  wire logic                   core_remote_sense,
	output logic                        peripheral_buck_clock_invert,
	output logic                        io_buck_clock_invert,
	output logic                        memory_buck_clock_invert,
	output logic                        processor_buck_clock_invert,
	output logic                        core_one_buck_clock_invert,
	output logic                        core_two_buck_clock_invert,
	output logic                        buck_rail_discharge_enable,
	output logic                        feedback_out_three_o,
	output logic                        feedback_out_three_oe,
	output logic                        feedback_out_two_o,
	output logic                        feedback_out_two_oe,
	output logic                        reset_out_assert,
	output logic                        hs_serial_continuous_fast,
	output logic                        hs_serial_fast_plus_timing,
	output logic                        input_supply_select,
	output logic                        system_enable,
	output logic                        interrupt_request_out,
	output logic [N_BUCK_RAILS-1:0]     buck_startup_enable,
	output logic [N_LIN_RAILS-1:0]      linear_startup_enable,
	output logic [3:0]                  linear_bypass_enable,
	output logic                        io_buck_regs_active,
	output logic                        core_two_regs_active,
	output logic                        core_one_full_current,
	output logic                        core_two_full_current,
	output logic                        processor_buck_full_current,
	output logic                        sense_on_feedback_pin_two,
	output logic                        sense_on_core_switch_sense_pin,
	output logic                        linear_eight_motor_driver
);

	logic [REG_W-1:0] clock_phase_q;
	logic [REG_W-1:0] output_if_q;
	logic [REG_W-1:0] buck_auto_q;
	logic [REG_W-1:0] lin_bypass_q;
	logic [REG_W-1:0] lin_auto_q;
	logic [REG_W-1:0] merge_mode_q;

	// Write and read channel registers and internal decode signals
	logic              aw_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic              w_held_q;
	logic [REG_W-1:0]  w_data_q;
	logic              w_lane0_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0]        rresp_q;
	logic              wr_fire;
	logic              wr_hit;
	logic [ADDR_W-1:0] wr_idx;
	logic              rd_fire;
	logic [ADDR_W-1:0] rd_idx;
	logic [REG_W-1:0]  rd_value;
	logic              rd_hit;
	logic [N_LIN_RAILS-1:0] lin_auto_bits;
	logic                   sense_fb_d;
	logic                   fb_two_open_drain;
	// Address and data are accepted independently, one write at a time
	assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
	assign wr_idx  = aw_addr_q >> BYTE_SHIFT;
	assign rd_fire = s_req.arvalid && !rvalid_q;
	assign rd_idx  = s_req.araddr >> BYTE_SHIFT;

	always_comb begin
		wr_hit = 1'b0;
		if (aw_addr_q[BYTE_SHIFT-1:0] == 2'h0) begin
			unique case (wr_idx)
				IDX_CLOCK_PHASE, IDX_OUTPUT_IF, IDX_BUCK_AUTO,
				IDX_LIN_BYPASS, IDX_LIN_AUTO, IDX_MERGE_MODE: wr_hit = 1'b1;
				default: wr_hit = 1'b0;
			endcase
		end
	end

	always_comb begin
		rd_value = '0;
		rd_hit   = s_req.araddr[BYTE_SHIFT-1:0] == 2'h0;
		unique case (rd_idx)
			IDX_CLOCK_PHASE: rd_value = clock_phase_q;
			IDX_OUTPUT_IF:   rd_value = output_if_q;
			IDX_BUCK_AUTO:   rd_value = buck_auto_q;
			IDX_LIN_BYPASS:  rd_value = lin_bypass_q;
			IDX_LIN_AUTO:    rd_value = lin_auto_q;
			IDX_MERGE_MODE:  rd_value = merge_mode_q;
			default:         rd_hit   = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_req.awvalid && !aw_held_q) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_req.awaddr;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q  <= 1'b0;
			w_data_q  <= '0;
			w_lane0_q <= 1'b0;
		end else if (s_req.wvalid && !w_held_q) begin
			w_held_q  <= 1'b1;
			w_data_q  <= s_req.wdata[REG_W-1:0];
			w_lane0_q <= s_req.wstrb[0];
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_req.bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			// Narrow registers sit in the low byte, upper bits read zero
			rdata_q  <= {{(DATA_W-REG_W){1'b0}}, rd_value};
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_req.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_rsp.awready = !aw_held_q;
	assign s_rsp.wready  = !w_held_q;
	assign s_rsp.bvalid  = bvalid_q;
	assign s_rsp.bresp   = bresp_q;
	assign s_rsp.arready = !rvalid_q;
	assign s_rsp.rvalid  = rvalid_q;
	assign s_rsp.rdata   = rdata_q;
	assign s_rsp.rresp   = rresp_q;
	// Full byte stored and read back
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_phase_q <= RST_CLOCK_PHASE;
			output_if_q   <= RST_OUTPUT_IF;
			buck_auto_q   <= RST_BUCK_AUTO;
			lin_bypass_q  <= RST_LIN_BYPASS;
			lin_auto_q    <= RST_LIN_AUTO;
			merge_mode_q  <= RST_MERGE_MODE;
		end else if (wr_fire && wr_hit && w_lane0_q) begin
			unique case (wr_idx)
				IDX_CLOCK_PHASE: clock_phase_q <= w_data_q;
				IDX_OUTPUT_IF:   output_if_q   <= w_data_q;
				IDX_BUCK_AUTO:   buck_auto_q   <= w_data_q;
				IDX_LIN_BYPASS:  lin_bypass_q  <= w_data_q;
				IDX_LIN_AUTO:    lin_auto_q    <= w_data_q;
				IDX_MERGE_MODE:  merge_mode_q  <= w_data_q;
				default:         ;
			endcase
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			peripheral_buck_clock_invert <= 1'b0;
			io_buck_clock_invert         <= 1'b0;
			memory_buck_clock_invert     <= 1'b0;
			processor_buck_clock_invert  <= 1'b0;
			core_one_buck_clock_invert   <= 1'b0;
			core_two_buck_clock_invert   <= 1'b1;
			buck_rail_discharge_enable   <= 1'b0;
		end else begin
			peripheral_buck_clock_invert <= clock_phase_q[B_PERI_CLK_INV];
			io_buck_clock_invert         <= clock_phase_q[B_IO_CLK_INV];
			memory_buck_clock_invert     <= clock_phase_q[B_MEM_CLK_INV];
			processor_buck_clock_invert  <= clock_phase_q[B_PRO_CLK_INV];
			core_one_buck_clock_invert   <= clock_phase_q[B_CORE1_CLK_INV];
			core_two_buck_clock_invert   <= ~clock_phase_q[B_CORE1_CLK_INV];
			buck_rail_discharge_enable   <= clock_phase_q[B_DISCHARGE];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_out_assert           <= 1'b1;
			hs_serial_continuous_fast  <= 1'b0;
			hs_serial_fast_plus_timing <= 1'b0;
			input_supply_select        <= 1'b0;
		end else begin
			reset_out_assert           <= reset_request | output_if_q[B_FORCE_RESET];
			hs_serial_continuous_fast  <= output_if_q[B_HS_CONT];
			hs_serial_fast_plus_timing <= output_if_q[B_HS_FMP];
			input_supply_select        <= output_if_q[B_SUPPLY_SEL];
		end
	end

	// The first OTP read always loads; the second one only when not kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			system_enable <= 1'b0;
		end else if (otp_read_done && !(otp_read_second && output_if_q[B_SYSEN_KEEP])) begin
			system_enable <= otp_system_en;
		end
	end

	// Deferral only masks the output; the pending event itself is held upstream
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_request_out <= 1'b0;
		end else begin
			interrupt_request_out <= irq_event_pending &&
				(!output_if_q[B_IRQ_DEFER] || power_mode_active);
		end
	end
	assign sense_fb_d = merge_mode_q[B_DUAL_PHASE] && core_remote_sense &&
		!merge_mode_q[B_SENSE_ROUTE];
	// Open drain only for power-good high
	assign fb_two_open_drain = fb_two_is_power_good && output_if_q[B_FB2_POL];

	feedback_pin_driver u_fb_three (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.source      (fb_three_source),
		.active_high (output_if_q[B_FB3_POL]),
		.open_drain  (1'b0),
		.enable      (1'b1),
		.pin_o       (feedback_out_three_o),
		.pin_oe      (feedback_out_three_oe)
	);

	feedback_pin_driver u_fb_two (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.source      (fb_two_source),
		.active_high (output_if_q[B_FB2_POL]),
		.open_drain  (fb_two_open_drain),
		.enable      (!sense_fb_d),
		.pin_o       (feedback_out_two_o),
		.pin_oe      (feedback_out_two_oe)
	);
	assign lin_auto_bits = {lin_bypass_q[B_L11_AUTO], lin_bypass_q[B_L9_AUTO],
		lin_auto_q[B_L8_AUTO], lin_auto_q[B_L7_AUTO], lin_auto_q[B_L3_AUTO]};

	generate
		for (genvar i = 0; i < N_BUCK_RAILS; i++) begin : g_buck_auto
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					buck_startup_enable[i] <= 1'b0;
				end else begin
					buck_startup_enable[i] <= buck_auto_q[i] | buck_conf_enable[i];
				end
			end
		end
		for (genvar j = 0; j < N_LIN_RAILS; j++) begin : g_lin_auto
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					linear_startup_enable[j] <= 1'b0;
				end else begin
					linear_startup_enable[j] <= lin_auto_bits[j] | linear_conf_enable[j];
				end
			end
		end
	endgenerate

	// Bypass vector order: {11, 8, 7, 3}
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			linear_bypass_enable <= '0;
		end else begin
			linear_bypass_enable <= {lin_bypass_q[B_L11_BYP], lin_bypass_q[B_L8_BYP],
				lin_bypass_q[B_L7_BYP], lin_bypass_q[B_L3_BYP]};
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_buck_regs_active            <= 1'b1;
			core_two_regs_active           <= 1'b1;
			core_one_full_current          <= 1'b0;
			core_two_full_current          <= 1'b0;
			processor_buck_full_current    <= 1'b0;
			sense_on_feedback_pin_two      <= 1'b0;
			sense_on_core_switch_sense_pin <= 1'b0;
			linear_eight_motor_driver      <= 1'b0;
		end else begin
			// Joined coil ignores IO buck registers
			io_buck_regs_active            <= ~merge_mode_q[B_MEM_IO_JOIN];
			// Dual phase ignores core two registers
			core_two_regs_active           <= ~merge_mode_q[B_DUAL_PHASE];
			core_one_full_current          <= merge_mode_q[B_CORE1_FULL];
			core_two_full_current          <= merge_mode_q[B_CORE2_FULL];
			processor_buck_full_current    <= merge_mode_q[B_PRO_FULL];
			sense_on_feedback_pin_two      <= sense_fb_d;
			sense_on_core_switch_sense_pin <= merge_mode_q[B_DUAL_PHASE] &&
				core_remote_sense && merge_mode_q[B_SENSE_ROUTE];
			linear_eight_motor_driver      <= merge_mode_q[B_L8_FUNC];
		end
	end

endmodule : pmic_power_config_bank

// file: tb/power_cfg_monitor.sv
// Checker for bus answers and derived outputs of the configuration bank
`timescale 1ns/10ps
module power_cfg_monitor
	import power_cfg_pkg::*;
(
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire axil_req_t               s_req,
	input wire axil_rsp_t               s_rsp,
	input wire logic [N_BUCK_RAILS-1:0] buck_conf_enable,
	input wire logic [N_LIN_RAILS-1:0]  linear_conf_enable,
	input wire logic                    irq_event_pending,
	input wire logic                    core_one_buck_clock_invert,
	input wire logic                    core_two_buck_clock_invert,
	input wire logic                    interrupt_request_out,
	input wire logic [N_BUCK_RAILS-1:0] buck_startup_enable,
	input wire logic [N_LIN_RAILS-1:0]  linear_startup_enable,
	input wire logic                    feedback_out_two_oe,
	input wire logic                    sense_on_feedback_pin_two,
	input wire logic                    sense_on_core_switch_sense_pin
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_taken;
		s_req.awvalid && s_rsp.awready && s_req.wvalid && s_rsp.wready;
	endsequence
	sequence s_wr_answer;
		##[1:2] s_rsp.bvalid;
	endsequence

	a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
		else $error("write not answered");
	a_read_answer: assert property (s_req.arvalid && s_rsp.arready |=> s_rsp.rvalid)
		else $error("read not answered");
	a_read_refuse: assert property (
		s_req.arvalid && s_rsp.arready && ((s_req.araddr >> BYTE_SHIFT) > IDX_MERGE_MODE)
		|=> s_rsp.rresp == RESP_SLVERR && s_rsp.rdata == 32'h0)
		else $error("unmapped read not refused");
	a_bresp_hold: assert property (
		s_rsp.bvalid && !s_req.bready |=> s_rsp.bvalid && $stable(s_rsp.bresp))
		else $error("write answer dropped");
	a_rdata_hold: assert property (
		s_rsp.rvalid && !s_req.rready |=> s_rsp.rvalid && $stable(s_rsp.rdata))
		else $error("read answer dropped");
	a_rdata_upper: assert property (s_rsp.rvalid |-> s_rsp.rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_core_opposite: assert property (
		core_two_buck_clock_invert == !core_one_buck_clock_invert)
		else $error("core clocks not opposite");
	a_buck_start_or: assert property (
		$past(aresetn) |-> (buck_startup_enable & $past(buck_conf_enable)) ==
		$past(buck_conf_enable))
		else $error("buck own enable lost");
	a_lin_start_or: assert property (
		$past(aresetn) |-> (linear_startup_enable & $past(linear_conf_enable)) ==
		$past(linear_conf_enable))
		else $error("linear own enable lost");
	a_irq_cause: assert property (interrupt_request_out |-> $past(irq_event_pending))
		else $error("interrupt without event");
	a_sense_route: assert property (
		sense_on_feedback_pin_two |-> !sense_on_core_switch_sense_pin && !feedback_out_two_oe)
		else $error("sense pin still driven");
endmodule : power_cfg_monitor

bind pmic_power_config_bank power_cfg_monitor mon_u (.*);

// file: tb/pmic_power_config_bank_bench.sv
// Self-checking bench for the power configuration register bank
`timescale 1ns/10ps
module pmic_power_config_bank_bench;
	import power_cfg_pkg::*;
	localparam logic [7:0] RV [6] = '{RST_CLOCK_PHASE, RST_OUTPUT_IF, RST_BUCK_AUTO,
		RST_LIN_BYPASS, RST_LIN_AUTO, RST_MERGE_MODE};
	logic            aclk, aresetn;
	axil_req_t       s_req;
	axil_rsp_t       s_rsp;
	logic [7:0]      buck_conf_enable, buck_startup_enable;
	logic [4:0]      linear_conf_enable, linear_startup_enable;
	logic [3:0]      linear_bypass_enable;
	logic            reset_request, irq_event_pending, power_mode_active, otp_read_done;
	logic            otp_read_second, otp_system_en, fb_three_source, fb_two_source;
	logic            fb_two_is_power_good, core_remote_sense, peripheral_buck_clock_invert;
	logic            io_buck_clock_invert, memory_buck_clock_invert, processor_buck_clock_invert;
	logic            core_one_buck_clock_invert, core_two_buck_clock_invert;
	logic            buck_rail_discharge_enable, feedback_out_three_o, feedback_out_three_oe;
	logic            feedback_out_two_o, feedback_out_two_oe, reset_out_assert;
	logic            hs_serial_continuous_fast, hs_serial_fast_plus_timing, input_supply_select;
	logic            system_enable, interrupt_request_out, io_buck_regs_active;
	logic            core_two_regs_active, core_one_full_current, core_two_full_current;
	logic            processor_buck_full_current, sense_on_feedback_pin_two;
	logic            sense_on_core_switch_sense_pin, linear_eight_motor_driver;
	int              fails, check_count;

	pmic_power_config_bank dut_u (.*);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic cmp_val(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp_val

	task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t response %h expected %h", $time, g, e);
		end
	endtask : cmp_resp

	// Ready and valid lines are looked at mid-cycle, where they are settled
	task automatic wait_rsp(input int k);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
			if (n > 99) begin
				fails++;
				$display("[FAIL] %0t no answer", $time);
				wrap_up();
			end
		end while ((k == 0 ? s_rsp.bvalid : k == 1 ? s_rsp.arready : s_rsp.rvalid) !== 1'b1);
	endtask : wait_rsp

	task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] st,
		output logic [1:0] r);
		logic a, w, ta, tw;
		a = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_req.awaddr <= 12'(idx << BYTE_SHIFT);
		s_req.wdata <= d;
		s_req.wstrb <= st;
		s_req.awvalid <= 1'b1;
		s_req.wvalid <= 1'b1;
		for (int n = 0; !(a && w); n++) begin
			if (n == 50) wait_rsp(3);
			@(negedge aclk);
			ta = s_req.awvalid && s_rsp.awready;
			tw = s_req.wvalid && s_rsp.wready;
			@(posedge aclk);
			if (ta) s_req.awvalid <= 1'b0;
			if (tw) s_req.wvalid <= 1'b0;
			a = a | ta;
			w = w | tw;
		end
		wait_rsp(0);
		r = s_rsp.bresp;
		// Late ready keeps the answer standing for one stalled cycle
		@(posedge aclk);
		s_req.bready <= 1'b1;
		@(posedge aclk);
		s_req.bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_req.araddr <= 12'(idx << BYTE_SHIFT);
		s_req.arvalid <= 1'b1;
		wait_rsp(1);
		@(posedge aclk);
		s_req.arvalid <= 1'b0;
		wait_rsp(2);
		d = s_rsp.rdata;
		r = s_rsp.rresp;
		@(posedge aclk);
		s_req.rready <= 1'b1;
		@(posedge aclk);
		s_req.rready <= 1'b0;
	endtask : rd

	task automatic wrc(input logic [11:0] idx, input logic [7:0] v);
		logic [31:0] d;
		logic [1:0]  r;
		wr(idx, {24'h0, v}, 4'hF, r);
		cmp_resp(RESP_OKAY, r);
		rd(idx, d, r);
		cmp_val({24'h0, v}, d);
	endtask : wrc

	task automatic settle;
		repeat (2) @(negedge aclk);
	endtask : settle

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 6; i++) begin
			rd(IDX_CLOCK_PHASE + 12'(i), d, r);
			cmp_val({24'h0, RV[i]}, d);
		end
		cmp_val(32'h1, 32'(core_two_buck_clock_invert));
		$display("test reset done");
	endtask : t_reset

	task automatic t_phase;
		logic [7:0] v [3] = '{8'h34, 8'hC8, 8'h03};
		for (int i = 0; i < 3; i++) begin
			wrc(IDX_CLOCK_PHASE, v[i]);
			cmp_val(32'(v[i][7:3]), 32'({peripheral_buck_clock_invert, io_buck_clock_invert,
				memory_buck_clock_invert, processor_buck_clock_invert,
				core_one_buck_clock_invert}));
			cmp_val(32'(!v[i][3]), 32'(core_two_buck_clock_invert));
			cmp_val(32'(v[i][2]), 32'(buck_rail_discharge_enable));
		end
		$display("test clock phase done");
	endtask : t_phase

	task automatic t_outif;
		logic [7:0] v [4] = '{8'h00, 8'hFF, 8'hA9, 8'h52};
		for (int i = 0; i < 4; i++) begin
			wrc(IDX_OUTPUT_IF, v[i]);
			cmp_val({30'h0, v[i][7], 1'b1}, 32'({feedback_out_three_o, feedback_out_three_oe}));
			cmp_val({30'h0, v[i][6], 1'b1}, 32'({feedback_out_two_o, feedback_out_two_oe}));
			cmp_val(32'({v[i][4], v[i][3], v[i][0]}), 32'({hs_serial_continuous_fast,
				hs_serial_fast_plus_timing, input_supply_select}));
			cmp_val(32'(v[i][5]), 32'(reset_out_assert));
		end
		@(posedge aclk);
		fb_two_is_power_good <= 1'b1;
		wrc(IDX_OUTPUT_IF, 8'h40);
		cmp_val(32'h0, 32'({feedback_out_two_o, feedback_out_two_oe}));
		@(posedge aclk);
		fb_two_source <= 1'b0;
		fb_three_source <= 1'b0;
		settle();
		cmp_val(32'h1, 32'({feedback_out_two_o, feedback_out_two_oe}));
		cmp_val(32'h3, 32'({feedback_out_three_o, feedback_out_three_oe}));
		wrc(IDX_OUTPUT_IF, 8'h00);
		cmp_val(32'h3, 32'({feedback_out_two_o, feedback_out_two_oe}));
		$display("test output interface done");
	endtask : t_outif

	task automatic otp_pulse(input logic e, input logic sec, input logic [7:0] v);
		wrc(IDX_OUTPUT_IF, v);
		@(posedge aclk);
		otp_system_en <= e;
		otp_read_second <= sec;
		otp_read_done <= 1'b1;
		@(posedge aclk);
		otp_read_done <= 1'b0;
		settle();
	endtask : otp_pulse

	task automatic t_ctrl;
		@(posedge aclk);
		irq_event_pending <= 1'b1;
		wrc(IDX_OUTPUT_IF, 8'h00);
		cmp_val(32'h1, 32'(interrupt_request_out));
		wrc(IDX_OUTPUT_IF, 8'h02);
		cmp_val(32'h0, 32'(interrupt_request_out));
		@(posedge aclk);
		power_mode_active <= 1'b1;
		settle();
		cmp_val(32'h1, 32'(interrupt_request_out));
		otp_pulse(1'b1, 1'b1, 8'h04);
		cmp_val(32'h0, 32'(system_enable));
		otp_pulse(1'b1, 1'b1, 8'h00);
		cmp_val(32'h1, 32'(system_enable));
		otp_pulse(1'b0, 1'b0, 8'h04);
		cmp_val(32'h0, 32'(system_enable));
		$display("test control done");
	endtask : t_ctrl

	task automatic t_start;
		@(posedge aclk);
		buck_conf_enable <= 8'h0F;
		linear_conf_enable <= 5'h01;
		wrc(IDX_BUCK_AUTO, 8'hA0);
		wrc(IDX_LIN_BYPASS, 8'hE9);
		wrc(IDX_LIN_AUTO, 8'h80);
		cmp_val(32'hAF, 32'(buck_startup_enable));
		cmp_val(32'h0D, 32'(linear_startup_enable));
		cmp_val(32'hF, 32'(linear_bypass_enable));
		@(posedge aclk);
		buck_conf_enable <= 8'h50;
		wrc(IDX_LIN_BYPASS, 8'h04);
		wrc(IDX_LIN_AUTO, 8'h44);
		cmp_val(32'hF0, 32'(buck_startup_enable));
		cmp_val(32'h13, 32'(linear_startup_enable));
		cmp_val(32'h0, 32'(linear_bypass_enable));
		$display("test start-up done");
	endtask : t_start

	task automatic t_merge;
		logic [7:0] v [3] = '{8'h88, 8'h7E, 8'h04};
		@(posedge aclk);
		core_remote_sense <= 1'b1;
		fb_two_is_power_good <= 1'b0;
		// Feedback control fields left untouched while routed
		for (int i = 0; i < 3; i++) begin
			wrc(IDX_MERGE_MODE, v[i]);
			cmp_val(32'({!v[i][7], !v[i][3]}),
				32'({io_buck_regs_active, core_two_regs_active}));
			cmp_val(32'(v[i][6:4]), 32'({core_one_full_current, core_two_full_current,
				processor_buck_full_current}));
			cmp_val(32'({v[i][3] & !v[i][2], v[i][3] & v[i][2]}), 32'({sense_on_feedback_pin_two,
				sense_on_core_switch_sense_pin}));
			if (v[i][3] && !v[i][2])
				cmp_val(32'h0, 32'({feedback_out_two_o, feedback_out_two_oe}));
			cmp_val(32'(v[i][1]), 32'(linear_eight_motor_driver));
		end
		$display("test merge done");
	endtask : t_merge

	task automatic t_bus;
		logic [31:0] d;
		logic [1:0]  r;
		rd(12'h10E, d, r);
		cmp_resp(RESP_SLVERR, r);
		cmp_val(32'h0, d);
		wr(12'h107, 32'hFF, 4'hF, r);
		cmp_resp(RESP_SLVERR, r);
		wr(IDX_BUCK_AUTO, 32'h11, 4'h0, r);
		cmp_resp(RESP_OKAY, r);
		rd(IDX_BUCK_AUTO, d, r);
		cmp_val(32'hA0, d);
		wr(IDX_LIN_AUTO, 32'hFFFFFF5A, 4'hF, r);
		rd(IDX_LIN_AUTO, d, r);
		cmp_val(32'h5A, d);
		$display("test bus done");
	endtask : t_bus

	initial begin
		fails = 0;
		check_count = 0;
		aresetn = 1'b0;
		s_req = '0;
		buck_conf_enable = '0;
		linear_conf_enable = '0;
		{reset_request, irq_event_pending, power_mode_active, otp_read_done} = '0;
		{otp_read_second, otp_system_en, fb_two_is_power_good, core_remote_sense} = '0;
		fb_three_source = 1'b1;
		fb_two_source = 1'b1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_phase();
		t_outif();
		t_ctrl();
		t_start();
		t_merge();
		t_bus();
		wrap_up();
	end
endmodule : pmic_power_config_bank_bench
